// ===== verification/qam_channel_datapath_bench.sv
// Self-checking bench for the channel datapath
module qam_channel_datapath_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0;
  logic        rst_b = 0;
  logic        clk_en = 1;
  logic        spi_clk = 0;
  logic        spi_cs_b = 1;
  logic        spi_sdi = 0;
  wire         spi_sdo;
  wire         spi_sdo_oe;
  wire  [63:0] ch_in_i, ch_in_q, ch_out_i, ch_out_q;
  wire  [3:0]  ch_in_valid, ch_in_ready, ch_out_valid;
  logic [63:0] last_i, last_q;
  logic [3:0]  last_v;
  int          mismatches = 0, checks = 0, out_cnt = 0;
  always #12.5 sys_clk = ~sys_clk;
  qam_channel_datapath dut_u (.sys_clk, .rst_b, .clk_en, .spi_clk,
    .spi_cs_b, .spi_sdi, .spi_sdo, .spi_sdo_oe, .ch_in_i, .ch_in_q,
    .ch_in_valid, .ch_in_ready, .ch_out_i, .ch_out_q, .ch_out_valid);
  symbol_source src_u (.sys_clk, .ch_in_ready, .ch_in_i, .ch_in_q,
    .ch_in_valid);
  // A held pulse during clk_en low is counted once, when state moves on
  always @(posedge sys_clk)
    if (ch_out_valid[0] === 1'b1 && clk_en)
    begin
      out_cnt++;
      last_i = ch_out_i;
      last_q = ch_out_q;
      last_v = ch_out_valid;
    end
  // ------
  // Helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Clock phases of five cycles keep above the four-cycle minimum
  task automatic spi(input logic [15:0] w, output logic [7:0] rd);
    int b;
    rd = 8'h00;
    @(posedge sys_clk);
    spi_cs_b <= 1'b0;
    for (b = 15; b >= 0; b--)
    begin
      spi_sdi <= w[b];
      repeat (5) @(posedge sys_clk);
      if (b < 8)
        rd[b] = spi_sdo;
      spi_clk <= 1'b1;
      repeat (5) @(posedge sys_clk);
      spi_clk <= 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    spi_cs_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    spi({1'b0, a, d}, v);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    spi({1'b1, a, 8'h00}, v);
    check(v, e);
  endtask
  task automatic send(input logic [15:0] i, input logic [15:0] q);
    int c0, k;
    c0 = out_cnt;
    src_u.offer(4'hf, i, q);
    for (k = 0; k < 300 && out_cnt <= c0; k++)
      @(posedge sys_clk);
    #1;
    check(out_cnt, c0 + 1);
  endtask
  // Feeds n words, freezes briefly once the last is taken, then counts the outputs
  task automatic count(input int n, input int exp);
    int c0, j;
    c0 = out_cnt;
    for (j = 0; j < n; j++)
      src_u.offer(4'hf, 16'h1000, 16'hf000);
    clk_en <= 1'b0;
    repeat (6) @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (250) @(posedge sys_clk);
    check(out_cnt - c0, exp);
  endtask
  function automatic logic [15:0] scaled(input logic [15:0] x,
    input logic [7:0] g);
    int p;
    p = ($signed(x) * $signed({1'b0, g}) + 16) >>> 5;
    p = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
    return p[15:0];
  endfunction
  function automatic int mag(input logic signed [15:0] v);
    return v < 0 ? -int'(v) : int'(v);
  endfunction
  // ------
  // Scenarios
  // ------
  task automatic test_regs();
    logic [6:0] ra [10] = '{7'h06, 7'h07, 7'h09, 7'h16, 7'h17, 7'h18,
      7'h19, 7'h1a, 7'h1b, 7'h00};
    logic [7:0] rv [10] = '{8'hff, 8'h00, 8'h20, 8'h00, 8'h00, 8'h80,
      8'h00, 8'h00, 8'h80, 8'h00};
    int n;
    for (n = 0; n < 10; n++)
      rd(ra[n], rv[n]);
    wr(7'h05, 8'h5a);
    rd(7'h05, 8'h00);
  endtask
  task automatic test_scalar();
    logic [15:0] sx [6] = '{16'h1234, 16'h4000, 16'ha000, 16'h0005,
      16'hfff9, 16'h7fff};
    logic [7:0] sg [6] = '{8'h20, 8'h40, 8'h40, 8'h0b, 8'h0b, 8'hff};
    int n, c;
    for (n = 0; n < 6; n++)
    begin
      wr(7'h09, sg[n]);
      send(sx[n], ~sx[n]);
      check(last_v, 4'hf);
      for (c = 0; c < 4; c++)
      begin
        check(last_i[c*16+:16], scaled(sx[n], sg[n]));
        check(last_q[c*16+:16], scaled(~sx[n], sg[n]));
      end
    end
    wr(7'h09, 8'h20);
  endtask
  task automatic test_mapper();
    logic signed [15:0] ri [256];
    logic signed [15:0] rq [256];
    logic [7:0] mask [8] = '{8'h3f, 8'hff, 8'h0f, 8'h1f, 8'h3f, 8'h7f,
      8'hff, 8'hff};
    int span [8] = '{14, 15, 15, 15, 14, 11, 15, 0};
    int m, x, k, top;
    wr(7'h06, 8'h7f);
    for (m = 0; m < 8; m++)
    begin
      wr(7'h07, m[7:0]);
      top = 0;
      for (x = 0; x < 256; x++)
      begin
        send(16'ha500 | x[15:0], 16'h0000);
        ri[x] = last_i[15:0];
        rq[x] = last_q[15:0];
        top = mag(ri[x]) > top ? mag(ri[x]) : top;
        top = mag(rq[x]) > top ? mag(rq[x]) : top;
        if (x > mask[m])
          check({ri[x], rq[x]}, {ri[x & mask[m]], rq[x & mask[m]]});
      end
      if (m == 0)
      begin
        k = ri[63] / 14;
        check(k == 0, 0);
        check(rq[63], 14 * k);
        check(ri[8'h1d], 6 * k);
        check(rq[8'h1d], -10 * k);
      end
      check(top, span[m] * k);
    end
    wr(7'h07, 8'h00);
  endtask
  task automatic test_interp();
    logic [7:0] cfg [7] = '{8'hff, 8'hfe, 8'hfd, 8'hfb, 8'hf7, 8'hef,
      8'he0};
    int mul [7] = '{1, 2, 2, 2, 2, 2, 32};
    int n;
    for (n = 0; n < 7; n++)
    begin
      wr(7'h06, cfg[n]);
      count(2, 2 * mul[n]);
    end
    for (n = 0; n < 4; n++)
    begin
      wr(7'h07, {2'b00, n[1:0], 4'h0});
      wr(7'h06, 8'ha0);
      count(2, 128);
    end
    wr(7'h06, 8'hff);
  endtask
  task automatic test_rate();
    logic [23:0] cp [3] = '{24'h40_0000, 24'h60_0000, 24'hb1_a000};
    logic [23:0] cq [3] = '{24'h80_0000, 24'h80_0000, 24'hc8_0000};
    int cn [3] = '{40, 40, 100};
    int n, b;
    logic [63:0] e;
    for (n = 0; n < 3; n++)
    begin
      for (b = 0; b < 3; b++)
      begin
        wr(7'h16 + b[6:0], cq[n][b*8+:8]);
        wr(7'h19 + b[6:0], cp[n][b*8+:8]);
      end
      e = cn[n];
      e = e * cp[n] / cq[n];
      count(cn[n], int'(e));
    end
    for (b = 0; b < 3; b++)
    begin
      rd(7'h16 + b[6:0], cq[2][b*8+:8]);
      rd(7'h19 + b[6:0], cp[2][b*8+:8]);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    test_regs();
    test_scalar();
    test_mapper();
    test_interp();
    test_rate();
    stop_test();
  end
  initial
  begin
    #2_000_000;
    mismatches++;
    stop_test();
  end
endmodule

// ===== verification/qam_datapath_checker_sva.sv
// Port assertions for the channel datapath
module qam_datapath_checker #(parameter NUM_CH = 4, parameter NUM_HB = 5)
(
  input logic                 sys_clk,
  input logic                 rst_b,
  input logic                 clk_en,
  input logic                 spi_clk,
  input logic                 spi_cs_b,
  input logic                 spi_sdi,
  input logic                 spi_sdo,
  input logic                 spi_sdo_oe,
  input logic [NUM_CH*16-1:0] ch_in_i,
  input logic [NUM_CH*16-1:0] ch_in_q,
  input logic [NUM_CH-1:0]    ch_in_valid,
  input logic [NUM_CH-1:0]    ch_in_ready,
  input logic [NUM_CH*16-1:0] ch_out_i,
  input logic [NUM_CH*16-1:0] ch_out_q,
  input logic [NUM_CH-1:0]    ch_out_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] since_take;
  logic [7:0] since_fall;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ------
  // Counters
  // ------
  // Take count only runs with clk_en, as the design is frozen otherwise
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      since_take <= 8'h00;
      since_fall <= 8'hff;
    end
    else
    begin
      if (clk_en && ch_in_valid[0] && ch_in_ready[0])
        since_take <= 8'h00;
      else if (clk_en && since_take != 8'hff)
        since_take <= since_take + 8'h01;
      if ($fell(spi_clk))
        since_fall <= 8'h00;
      else if (since_fall != 8'hff)
        since_fall <= since_fall + 8'h01;
    end
  end
  sequence rd_bit_edge;
    spi_sdo_oe && $rose(spi_clk);
  endsequence
  sequence rd_bit_kept;
    $stable(spi_sdo) [*3];
  endsequence
  // ------
  // Assertions
  // ------
  a_reset_idle: assert property ($rose(rst_b) |->
    !(|ch_out_valid) && !spi_sdo_oe && &ch_in_ready)
    else $error("outputs not idle after reset");
  a_out_held: assert property (!ch_out_valid[0] |->
    $stable(ch_out_i[15:0]) && $stable(ch_out_q[15:0]))
    else $error("output data moved without valid");
  a_out_cause: assert property (ch_out_valid[0] |->
    since_take < 8'h96)
    else $error("output without a recent input");
  a_ready_idle: assert property (since_take > 8'hc8 |->
    ch_in_ready[0])
    else $error("ready low while idle");
  a_freeze_holds: assert property (!clk_en |=>
    $stable(ch_out_valid) && $stable(ch_out_i))
    else $error("state moved with clk_en low");
  a_oe_in_frame: assert property (spi_sdo_oe |->
    $past(spi_cs_b, 6) == 1'b0)
    else $error("sdo driven outside a frame");
  a_sdo_after_fall: assert property (spi_sdo_oe && $past(spi_sdo_oe)
    && $changed(spi_sdo) |-> since_fall < 8'h07)
    else $error("sdo changed away from a clock fall");
  a_sdo_steady: assert property (rd_bit_edge |=> rd_bit_kept)
    else $error("sdo moved around a rising clock");
endmodule
bind qam_channel_datapath qam_datapath_checker #(.NUM_CH(NUM_CH),
  .NUM_HB(NUM_HB)) chk_u (.sys_clk, .rst_b, .clk_en, .spi_clk, .spi_cs_b,
  .spi_sdi, .spi_sdo, .spi_sdo_oe, .ch_in_i, .ch_in_q, .ch_in_valid,
  .ch_in_ready, .ch_out_i, .ch_out_q, .ch_out_valid);

// ===== verification/symbol_source.sv
// Upstream model offering one word to each selected channel
module symbol_source #(parameter NUM_CH = 4)
(
  input  logic                 sys_clk,
  input  logic [NUM_CH-1:0]    ch_in_ready,
  output logic [NUM_CH*16-1:0] ch_in_i,
  output logic [NUM_CH*16-1:0] ch_in_q,
  output logic [NUM_CH-1:0]    ch_in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ch_in_i = '0;
    ch_in_q = '0;
    ch_in_valid = '0;
  end
  // Word held until ready seen; then lines show the inverse, so a late
  // read of stale data cannot pass by luck
  task automatic offer(input logic [NUM_CH-1:0] m, input logic [15:0] i,
    input logic [15:0] q);
    logic [NUM_CH-1:0] left;
    left = m;
    @(posedge sys_clk);
    ch_in_valid <= m;
    ch_in_i <= {NUM_CH{i}};
    ch_in_q <= {NUM_CH{q}};
    while (left != '0)
    begin
      @(negedge sys_clk);
      left = left & ~ch_in_ready;
      @(posedge sys_clk);
      ch_in_valid <= left;
    end
    ch_in_i <= ~{NUM_CH{i}};
    ch_in_q <= ~{NUM_CH{q}};
  endtask
endmodule

// ===== verilog/qam_channel_datapath.v
// Channel datapaths: mapper, input scalar, interpolators, rate converter
`include "qam_datapath_defs.vh"

// ----------------------------------------------------------------
// 2x interpolator, symmetric 4-tap odd phase, I and Q lanes
// ----------------------------------------------------------------
module interp2 #(parameter W = 16)
(
  input  wire         sys_clk,
  input  wire         rst_b,
  input  wire         clk_en,
  input  wire         byp,
  input  wire [8:0]   k1,
  input  wire [8:0]   k2,
  input  wire [W-1:0] in_i,
  input  wire [W-1:0] in_q,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_i,
  output wire [W-1:0] out_q,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [4*W-1:0] hist_i;
  reg [4*W-1:0] hist_q;
  reg [W-1:0]   oi;
  reg [W-1:0]   oq;
  reg           ov;
  reg           pend;

  function [W-1:0] mid;
    input [4*W-1:0] h;
    input [8:0]     a;
    input [8:0]     b;
    reg signed [W:0]    s1;
    reg signed [W:0]    s2;
    reg signed [W+10:0] acc;
    begin
      s1 = $signed(h[2*W-1:W]) + $signed(h[3*W-1:2*W]);
      s2 = $signed(h[W-1:0]) + $signed(h[4*W-1:3*W]);
      acc = s1 * $signed(a) + s2 * $signed(b);
      mid = acc[W+7:8];
    end
  endfunction

  // Bypassed stage is a wire; active stage takes one input per two outputs
  assign in_ready  = byp ? out_ready : (!pend && (!ov || out_ready));
  assign out_valid = byp ? in_valid : ov;
  assign out_i     = byp ? in_i : oi;
  assign out_q     = byp ? in_q : oq;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hist_i <= {4*W{1'b0}};
      hist_q <= {4*W{1'b0}};
      oi     <= {W{1'b0}};
      oq     <= {W{1'b0}};
      ov     <= 1'b0;
      pend   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (pend && (!ov || out_ready))
      begin
        oi   <= mid(hist_i, k1, k2);
        oq   <= mid(hist_q, k1, k2);
        ov   <= 1'b1;
        pend <= 1'b0;
      end
      else if (in_valid && in_ready && !byp)
      begin
        hist_i <= {hist_i[3*W-1:0], in_i};
        hist_q <= {hist_q[3*W-1:0], in_q};
        oi     <= hist_i[2*W-1:W];
        oq     <= hist_q[2*W-1:W];
        ov     <= 1'b1;
        pend   <= 1'b1;
      end
      else if (ov && out_ready)
        ov <= 1'b0;
    end
  end
endmodule

// Summary of operation
// - One stage bypass setting serves every channel at once.
// - Mapper takes 8-bit words, gives 5-bit I and Q per symbol.
// - Three-bit mode field selects one of seven mappings, code 111 unused.
// - Only the low input bits the constellation needs are used.
// - Coordinates span 14 for 64-point, 11 for 128, else 15.
// - Coordinates leave as 5-bit two's complement values.
// - Mapper and root cosine bypassed: input multiplied by gain over 32, reset unity.
// - Scalar rounds to 16 bits and saturates to full scale.
// - Root cosine stage interpolates by two, roll-off from 2-bit field.
// - Root cosine stage takes 5 bits, bypassable, MSBs of raw word.
// - Five separately bypassable 2x half-band stages, 1x to 32x.
// - Half-band stages: symmetric 4-tap odd phase, inner 144/256, outer -16/256.
// - Rate converter ratio P over Q, two 24-bit values, 0.5 to 1.
// - Q bytes at 0x16-0x18, P bytes at 0x19-0x1B, low first.
// - Accumulator keeps long-term output rate exact, no drift.
module qam_channel_datapath #(parameter NUM_CH = 4, parameter NUM_HB = 5)
(
  input  wire                 sys_clk,
  input  wire                 rst_b,
  input  wire                 clk_en,
  input  wire                 spi_clk,
  input  wire                 spi_cs_b,
  input  wire                 spi_sdi,
  output reg                  spi_sdo,
  output wire                 spi_sdo_oe,
  input  wire [NUM_CH*16-1:0] ch_in_i,
  input  wire [NUM_CH*16-1:0] ch_in_q,
  input  wire [NUM_CH-1:0]    ch_in_valid,
  output wire [NUM_CH-1:0]    ch_in_ready,
  output wire [NUM_CH*16-1:0] ch_out_i,
  output wire [NUM_CH*16-1:0] ch_out_q,
  output wire [NUM_CH-1:0]    ch_out_valid
);
  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  reg  [7:0]  stage_bypass;
  reg  [7:0]  mapper_cfg;
  reg  [7:0]  input_gain;
  reg  [23:0] rate_den;
  reg  [23:0] rate_num;
  reg         sck_s1;
  reg         sck_s2;
  reg         sck_s3;
  reg         cs_s1;
  reg         cs_s2;
  reg         sdi_s1;
  reg         sdi_s2;
  reg  [15:0] sh;
  reg  [4:0]  cnt;
  reg  [7:0]  rd_sh;
  reg         rd_cmd;
  reg  [7:0]  rd_data;
  wire [6:0]  rd_addr = {sh[5:0], sdi_s2};
  wire [6:0]  wr_addr = sh[13:7];
  wire [7:0]  wr_data = {sh[6:0], sdi_s2};
  wire        sck_rise = sck_s2 && !sck_s3;
  wire        sck_fall = !sck_s2 && sck_s3;

  assign spi_sdo_oe = !cs_s2 && rd_cmd && cnt > `SPI_CMD_LAST;

  always @*
  begin
    case (rd_addr)
      `ADDR_STAGE_BYPASS: rd_data = stage_bypass;
      `ADDR_MAPPER_CFG:   rd_data = mapper_cfg;
      `ADDR_INPUT_GAIN:   rd_data = input_gain;
      `ADDR_DEN_BYTE0:    rd_data = rate_den[7:0];
      `ADDR_DEN_BYTE1:    rd_data = rate_den[15:8];
      `ADDR_DEN_BYTE2:    rd_data = rate_den[23:16];
      `ADDR_NUM_BYTE0:    rd_data = rate_num[7:0];
      `ADDR_NUM_BYTE1:    rd_data = rate_num[15:8];
      `ADDR_NUM_BYTE2:    rd_data = rate_num[23:16];
      default:            rd_data = 8'h00;
    endcase
  end

  // Pins are slow against sys_clk; edges are found after two flops
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {sck_s1, sck_s2, sck_s3} <= 3'h0;
      {cs_s1, cs_s2}           <= 2'h3;
      {sdi_s1, sdi_s2}         <= 2'h0;
      sh           <= 16'h0000;
      cnt          <= 5'h00;
      rd_sh        <= 8'h00;
      rd_cmd       <= 1'b0;
      spi_sdo      <= 1'b0;
      stage_bypass <= `RST_STAGE_BYPASS;
      mapper_cfg   <= `RST_MAPPER_CFG;
      input_gain   <= `RST_INPUT_GAIN;
      rate_den     <= `RST_DEN;
      rate_num     <= `RST_NUM;
    end
    else if (clk_en)
    begin
      sck_s1 <= spi_clk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1  <= spi_cs_b;
      cs_s2  <= cs_s1;
      sdi_s1 <= spi_sdi;
      sdi_s2 <= sdi_s1;
      if (cs_s2)
      begin
        cnt    <= 5'h00;
        rd_cmd <= 1'b0;
      end
      else if (sck_rise && cnt <= `SPI_LAST_BIT)
      begin
        sh  <= {sh[14:0], sdi_s2};
        cnt <= cnt + 5'h01;
        if (cnt == `SPI_CMD_LAST)
        begin
          rd_cmd <= sh[6];
          rd_sh  <= rd_data;
        end
        if (cnt == `SPI_LAST_BIT && !sh[14])
        begin
          case (wr_addr)
            `ADDR_STAGE_BYPASS: stage_bypass <= wr_data;
            `ADDR_MAPPER_CFG:   mapper_cfg <= wr_data;
            `ADDR_INPUT_GAIN:   input_gain <= wr_data;
            `ADDR_DEN_BYTE0:    rate_den[7:0] <= wr_data;
            `ADDR_DEN_BYTE1:    rate_den[15:8] <= wr_data;
            `ADDR_DEN_BYTE2:    rate_den[23:16] <= wr_data;
            `ADDR_NUM_BYTE0:    rate_num[7:0] <= wr_data;
            `ADDR_NUM_BYTE1:    rate_num[15:8] <= wr_data;
            `ADDR_NUM_BYTE2:    rate_num[23:16] <= wr_data;
            default:            rate_num <= rate_num;
          endcase
        end
      end
      else if (sck_fall && cnt > `SPI_CMD_LAST)
      begin
        spi_sdo <= rd_sh[7];
        rd_sh   <= {rd_sh[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Mapper and input scalar
  // ----------------------------------------------------------------
  wire       map_byp = stage_bypass[`MAP_BYPASS_BIT];
  wire       rrc_byp = stage_bypass[`RRC_BYPASS_BIT];
  wire [2:0] mode = mapper_cfg[`MAP_MODE_MSB:`MAP_MODE_LSB];
  wire [1:0] alpha = mapper_cfg[`ROLLOFF_MSB:`ROLLOFF_LSB];
  wire [35:0] k1_tab = `RRC_K1_TABLE;
  wire [35:0] k2_tab = `RRC_K2_TABLE;
  wire [8:0]  rrc_k1 = k1_tab[alpha*9 +: 9];
  wire [8:0]  rrc_k2 = k2_tab[alpha*9 +: 9];

  // Returns {I, Q}; grid level l maps to (2l - g) * k
  function [9:0] qam_map;
    input [2:0] m;
    input [7:0] s;
    reg [3:0] li;
    reg [3:0] lq;
    integer   g;
    integer   k;
    integer   ci;
    integer   cq;
    begin
      li = 4'h0;
      lq = 4'h0;
      g = 0;
      k = 0;
      case (m)
        `MODE_B64, `MODE_A64:
        begin
          li = {1'b0, s[2:0]};
          lq = {1'b0, s[5], s[4] ^ ~s[5], s[3]};
          g = 7;
          k = 2;
        end
        `MODE_B256, `MODE_A256:
        begin
          li = s[3:0];
          lq = {s[7], s[6] ^ ~s[7], s[5:4]};
          g = 15;
          k = 1;
        end
        `MODE_A16:
        begin
          li = {2'h0, s[1:0]};
          lq = {2'h0, s[3], s[2] ^ ~s[3]};
          g = 3;
          k = 5;
        end
        `MODE_A32:
        begin
          // 6x6 grid without corners: inner square plus edge strips
          li = 4'h1 + s[1:0];
          lq = !s[4] ? 4'h1 + s[3:2] : (s[2] ? 4'h5 : 4'h0);
          if (s[4] && !s[3])
          begin
            lq = 4'h1 + s[1:0];
            li = s[2] ? 4'h5 : 4'h0;
          end
          g = 5;
          k = 3;
        end
        `MODE_A128:
        begin
          li = 4'h2 + s[2:0];
          lq = !s[6] ? 4'h2 + s[5:3] : (s[4] ? 4'ha : 4'h0) + s[3];
          if (s[6] && !s[5])
          begin
            lq = 4'h2 + s[2:0];
            li = (s[4] ? 4'ha : 4'h0) + s[3];
          end
          g = 11;
          k = 1;
        end
        default:
        begin
          li = 4'h0;
          lq = 4'h0;
        end
      endcase
      ci = (2 * li - g) * k;
      cq = (2 * lq - g) * k;
      qam_map = {ci[4:0], cq[4:0]};
    end
  endfunction

  function [15:0] scale;
    input [15:0] x;
    input [7:0]  gn;
    reg signed [24:0] p;
    begin
      p = $signed(x) * $signed({1'b0, gn}) + $signed(`GAIN_ROUND);
      p = p >>> `GAIN_SHIFT;
      if (p[24:15] != {10{p[24]}})
        scale = p[24] ? 16'h8000 : 16'h7fff;
      else
        scale = p[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Per-channel chains; all share the one set of stage controls
  // ----------------------------------------------------------------
  genvar c;
  genvar h;
  generate
    for (c = 0; c < NUM_CH; c = c + 1)
    begin : chan
      wire [15:0] xi = ch_in_i[c*16 +: 16];
      wire [15:0] xq = ch_in_q[c*16 +: 16];
      wire [9:0]  sym = qam_map(mode, xi[7:0]);
      wire [15:0] fi;
      wire [15:0] fq;
      wire [15:0] si [0:NUM_HB+1];
      wire [15:0] sq [0:NUM_HB+1];
      wire [NUM_HB+1:0] sv;
      wire [NUM_HB+1:0] sr;
      reg  [15:0] prev_i;
      reg  [15:0] prev_q;
      reg  [24:0] acc;
      reg  [15:0] oi;
      reg  [15:0] oq;
      reg         ov;
      wire [24:0] acc_add = acc + {1'b0, rate_num};
      wire [24:0] resid = acc_add - {1'b0, rate_den};
      wire        emit = acc_add >= {1'b0, rate_den};
      // Scalar applies only while the mapper is bypassed
      assign fi = map_byp ? scale(xi, input_gain) : {sym[9:5], 11'h000};
      assign fq = map_byp ? scale(xq, input_gain) : {sym[4:0], 11'h000};
      // Root cosine first after a bypassed mapper sees raw MSBs
      assign si[0] = (map_byp && !rrc_byp) ? {xi[7:3], 11'h000} : fi;
      assign sq[0] = (map_byp && !rrc_byp) ? {xq[7:3], 11'h000} : fq;
      assign sv[0] = ch_in_valid[c];
      assign ch_in_ready[c] = sr[0];
      interp2 #(.W(16)) rrc (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .byp       (rrc_byp),
        .k1        (rrc_k1),
        .k2        (rrc_k2),
        .in_i      (si[0]),
        .in_q      (sq[0]),
        .in_valid  (sv[0]),
        .in_ready  (sr[0]),
        .out_i     (si[1]),
        .out_q     (sq[1]),
        .out_valid (sv[1]),
        .out_ready (sr[1])
      );
      for (h = 0; h < NUM_HB; h = h + 1)
      begin : hb
        interp2 #(.W(16)) stage (
          .sys_clk   (sys_clk),
          .rst_b     (rst_b),
          .clk_en    (clk_en),
          .byp       (stage_bypass[`HB_BYPASS_LSB + h]),
          .k1        (`HB_K1),
          .k2        (`HB_K2),
          .in_i      (si[h+1]),
          .in_q      (sq[h+1]),
          .in_valid  (sv[h+1]),
          .in_ready  (sr[h+1]),
          .out_i     (si[h+2]),
          .out_q     (sq[h+2]),
          .out_valid (sv[h+2]),
          .out_ready (sr[h+2])
        );
      end
      // Converter drops samples; exact integer accumulator, no drift
      assign sr[NUM_HB+1] = 1'b1;
      assign ch_out_i[c*16 +: 16] = oi;
      assign ch_out_q[c*16 +: 16] = oq;
      assign ch_out_valid[c] = ov;
      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          prev_i <= 16'h0000;
          prev_q <= 16'h0000;
          acc    <= 25'h00_0000;
          oi     <= 16'h0000;
          oq     <= 16'h0000;
          ov     <= 1'b0;
        end
        else if (clk_en)
        begin
          ov <= 1'b0;
          if (sv[NUM_HB+1])
          begin
            prev_i <= si[NUM_HB+1];
            prev_q <= sq[NUM_HB+1];
            acc    <= emit ? resid : acc_add;
            if (emit)
            begin
              // Nearest of the two input samples around the output instant
              oi <= (resid >= {2'h0, rate_num[23:1]}) ? prev_i
                                                       : si[NUM_HB+1];
              oq <= (resid >= {2'h0, rate_num[23:1]}) ? prev_q
                                                       : sq[NUM_HB+1];
              ov <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate
endmodule

// ===== verilog/qam_datapath_defs.vh
// Register map, reset values, field positions and filter constants
`ifndef QAM_DATAPATH_DEFS_VH
`define QAM_DATAPATH_DEFS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_STAGE_BYPASS 7'h06
`define ADDR_MAPPER_CFG   7'h07
`define ADDR_INPUT_GAIN   7'h09
`define ADDR_DEN_BYTE0    7'h16
`define ADDR_DEN_BYTE1    7'h17
`define ADDR_DEN_BYTE2    7'h18
`define ADDR_NUM_BYTE0    7'h19
`define ADDR_NUM_BYTE1    7'h1a
`define ADDR_NUM_BYTE2    7'h1b
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_STAGE_BYPASS  8'hff
`define RST_MAPPER_CFG    8'h00
`define RST_INPUT_GAIN    8'h20
`define RST_DEN           24'h80_0000
`define RST_NUM           24'h80_0000
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MAP_BYPASS_BIT    7
`define RRC_BYPASS_BIT    6
`define HB_BYPASS_LSB     0
`define MAP_MODE_MSB      2
`define MAP_MODE_LSB      0
`define ROLLOFF_MSB       5
`define ROLLOFF_LSB       4
// ----------------------------------------------------------------
// Mapper modes
// ----------------------------------------------------------------
`define MODE_B64          3'h0
`define MODE_B256         3'h1
`define MODE_A16          3'h2
`define MODE_A32          3'h3
`define MODE_A64          3'h4
`define MODE_A128         3'h5
`define MODE_A256         3'h6
// ----------------------------------------------------------------
// Arithmetic constants (coefficients in 1/256) and serial bit counts
// ----------------------------------------------------------------
`define GAIN_ROUND        25'h00_0010
`define GAIN_SHIFT        5
`define HB_K1             9'h090
`define HB_K2             9'h1f0
`define RRC_K1_TABLE      36'h4_a24d_2490
`define RRC_K2_TABLE      36'hf_67b7_ddf0
`define SPI_LAST_BIT      5'h0f
`define SPI_CMD_LAST      5'h07
`endif
